// ==== pkg/ecc_pkg.sv ====
package ecc_pkg;
	localparam logic [4:0] OFS_END_FLAG_SECOND_LAST = 5'h0c;
	localparam logic [4:0] OFS_END_FLAG_LAST        = 5'h0d;
	localparam logic [4:0] OFS_MAX_FRAGMENT_SIZE    = 5'h0e;
	localparam logic [4:0] OFS_IRQ_ZERO_CONTROL     = 5'h0f;
	localparam logic [4:0] OFS_LINK_ERROR_CAPTURE   = 5'h10;
	localparam logic [4:0] OFS_DOUBLE_BLOCK_CAPTURE = 5'h11;
	localparam logic [4:0] OFS_TEST_CONTROL         = 5'h12;
	localparam logic [4:0] OFS_TEST_LINK_DATA       = 5'h13;
	localparam logic [4:0] OFS_TEST_LINK_STATUS     = 5'h14;

	localparam int ADDR_W      = 18;
	localparam int MAXSIZE_W   = 18;
	localparam int CAP_OVR_BIT = 18;

	localparam int IRQ0_EMPTY_BIT = 0;
	localparam int IRQ0_FULL_BIT  = 1;
	localparam int IRQ0_OVFL_BIT  = 2;
	localparam int IRQ0_MASK_LSB  = 3;

	localparam int TEST_INJECT_BIT = 0;
	localparam int TEST_MODE_BIT   = 1;
	localparam int TSTAT_CTRL_BIT  = 0;
	localparam int TSTAT_ERR_BIT   = 1;

	localparam int PAGE_WORDS = 8;
	localparam int PAGE_COUNT = 4;
	localparam int SUM_DEPTH  = PAGE_WORDS * PAGE_COUNT;

	localparam int POS_START_WORD = 0;
	localparam int POS_START_ADDR = 1;
	localparam int POS_START_FLAG = 2;
	localparam int POS_END_FLAG0  = 5;
	localparam int POS_END_FLAG1  = 6;
	localparam int POS_END_WORD   = 7;

	localparam logic [31:0] RST_WORD     = 32'h0000_0000;
	localparam logic [17:0] RST_MAXSIZE  = 18'h3ffff;
	localparam logic [5:0]  RST_IRQ0     = 6'h00;
	localparam logic [1:0]  RST_TEST     = 2'h0;

	typedef enum logic [1:0] {
		ECC_BLK_IDLE = 2'b01,
		ECC_BLK_OPEN = 2'b10
	} ecc_blk_e;
endpackage

// ==== verilog/ecc_event_capture_control_regs.sv ====
`timescale 1ns/100ps
// Operation
// - end flag register bit0 enables flag
// - flags pick second-last and last words
// - drop words beyond maximum fragment size
// - irq0 status bits empty, full, overflow
// - writing one clears irq0 status bit
// - bits 3-5 mask irq0 status setting
// - link error register returns word address
// - bit18 flags unread capture overwritten
// - any write clears capture interrupt
// - double start or end raises interrupt
// - test bit1 replaces link by host
// - rising test bit0 injects one word
// - test data and status register layout
// - summary fifo holds 8-word pages
// - page word order positions 0 to 7
// - disabled words undefined, restart overwrites
// - logic reset from global or flag1
// - link reset from flag0 only
// - freeze stops taking link fifo words
// - flag3 high while summary fifo empty
// - start flag index and enable bits
module ecc_event_capture_control_regs
	import ecc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        reg_sel,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata_ff,
	input  wire logic        sum_sel,
	input  wire logic        sum_rd,
	output logic      [31:0] sum_rdata_ff,
	input  wire logic        host_flag_link_rst_n,
	input  wire logic        host_flag_logic_rst_n,
	input  wire logic        host_flag_freeze_n,
	output logic             host_flag_fifo_empty_ff,
	output logic             link_interface_reset_n_ff,
	output logic             logic_rst_n_ff,
	input  wire logic        lfifo_valid,
	input  wire logic [31:0] lfifo_data,
	input  wire logic        link_control_word_indication_n,
	input  wire logic        link_error_indication_n,
	output logic             link_take_ff,
	output logic             pipe_valid_ff,
	output logic      [31:0] pipe_data_ff,
	output logic             pipe_ctrl_n_ff,
	output logic             pipe_err_n_ff,
	input  wire logic        cls_valid,
	input  wire logic [31:0] cls_data,
	input  wire logic        cls_start,
	input  wire logic        cls_end,
	input  wire logic        cls_err_n,
	input  wire logic [17:0] cls_addr,
	input  wire logic [2:0]  cls_start_flag,
	output logic             mem_wr_ff,
	output logic      [17:0] mem_addr_ff,
	output logic      [31:0] mem_data_ff,
	output logic             fifo_overflow_irq_out_n_ff,
	output logic             link_error_irq_out_n_ff,
	output logic             double_block_irq_out_n_ff
);
	logic            lrst;
	logic            wr_hit;
	logic            rd_hit;
	logic [1:0]      end_en_ff;
	logic [17:0]     max_size_ff;
	logic [2:0]      irq0_stat_ff;
	logic [2:0]      irq0_mask_ff;
	logic [1:0]      test_ctrl_ff;
	logic [31:0]     test_data_ff;
	logic [1:0]      test_stat_ff;
	logic            inj;
	ecc_blk_e        blk_ff;
	logic [17:0]     frag_cnt_ff;
	logic            trunc_ff;
	logic            drop;
	logic            ovfl_evt;
	logic            dbl_evt;
	logic            err_evt;
	logic [17:0]     le_addr_ff;
	logic            le_ovr_ff;
	logic            le_act_ff;
	logic            le_unread_ff;
	logic [17:0]     db_addr_ff;
	logic            db_ovr_ff;
	logic            db_act_ff;
	logic            db_unread_ff;
	logic [31:0]     prev1_ff;
	logic [31:0]     prev2_ff;
	logic [31:0]     page_ff [PAGE_WORDS];
	logic            commit_ff;
	logic [31:0]     sum_mem [SUM_DEPTH];
	logic [2:0]      wr_page_ff;
	logic [5:0]      rd_ptr_ff;
	logic            sum_empty;
	logic            sum_full;
	logic [2:0]      nxt_irq0;

	// both resets are synchronous; flag1 low acts like board reset
	assign lrst   = !rstn || !host_flag_logic_rst_n;
	assign wr_hit = reg_sel && reg_wr;
	assign rd_hit = reg_sel && reg_rd;
	assign inj    = wr_hit && reg_addr == OFS_TEST_CONTROL && test_ctrl_ff[TEST_MODE_BIT]
		&& reg_wdata[TEST_MODE_BIT] && reg_wdata[TEST_INJECT_BIT]
		&& !test_ctrl_ff[TEST_INJECT_BIT];

	always_ff @(posedge ref_clk) begin
		logic_rst_n_ff <= !lrst;
	end

	// link side deliberately survives global reset
	always_ff @(posedge ref_clk) begin
		link_interface_reset_n_ff <= host_flag_link_rst_n;
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			end_en_ff    <= 2'h0;
			max_size_ff  <= RST_MAXSIZE;
			irq0_mask_ff <= RST_IRQ0[5:3];
			test_ctrl_ff <= RST_TEST;
			test_data_ff <= RST_WORD;
			test_stat_ff <= RST_TEST;
		end else if (wr_hit) begin
			case (reg_addr)
				OFS_END_FLAG_SECOND_LAST: end_en_ff[0] <= reg_wdata[0];
				OFS_END_FLAG_LAST:        end_en_ff[1] <= reg_wdata[0];
				OFS_MAX_FRAGMENT_SIZE:    max_size_ff <= reg_wdata[MAXSIZE_W-1:0];
				OFS_IRQ_ZERO_CONTROL:     irq0_mask_ff <= reg_wdata[IRQ0_MASK_LSB +: 3];
				OFS_TEST_CONTROL:         test_ctrl_ff <= reg_wdata[1:0];
				OFS_TEST_LINK_DATA:       test_data_ff <= reg_wdata;
				OFS_TEST_LINK_STATUS:     test_stat_ff <= reg_wdata[1:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			reg_rdata_ff <= RST_WORD;
		end else if (rd_hit) begin
			case (reg_addr)
				OFS_END_FLAG_SECOND_LAST: reg_rdata_ff <= {31'h0, end_en_ff[0]};
				OFS_END_FLAG_LAST:        reg_rdata_ff <= {31'h0, end_en_ff[1]};
				OFS_MAX_FRAGMENT_SIZE:    reg_rdata_ff <= {14'h0, max_size_ff};
				OFS_IRQ_ZERO_CONTROL:     reg_rdata_ff <= {26'h0, irq0_mask_ff, irq0_stat_ff};
				OFS_LINK_ERROR_CAPTURE:   reg_rdata_ff <= {13'h0, le_ovr_ff, le_addr_ff};
				OFS_DOUBLE_BLOCK_CAPTURE: reg_rdata_ff <= {13'h0, db_ovr_ff, db_addr_ff};
				OFS_TEST_CONTROL:         reg_rdata_ff <= {30'h0, test_ctrl_ff};
				OFS_TEST_LINK_DATA:       reg_rdata_ff <= test_data_ff;
				OFS_TEST_LINK_STATUS:     reg_rdata_ff <= {30'h0, test_stat_ff};
				default:                  reg_rdata_ff <= RST_WORD;
			endcase
		end
	end

	// input selection: link fifo, or host words while in test mode
	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			link_take_ff <= 1'b0;
		end else begin
			link_take_ff <= host_flag_freeze_n && host_flag_link_rst_n
				&& !test_ctrl_ff[TEST_MODE_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			pipe_valid_ff  <= 1'b0;
			pipe_data_ff   <= RST_WORD;
			pipe_ctrl_n_ff <= 1'b1;
			pipe_err_n_ff  <= 1'b1;
		end else if (inj) begin
			pipe_valid_ff  <= 1'b1;
			pipe_data_ff   <= test_data_ff;
			pipe_ctrl_n_ff <= test_stat_ff[TSTAT_CTRL_BIT];
			pipe_err_n_ff  <= test_stat_ff[TSTAT_ERR_BIT];
		end else if (link_take_ff && !test_ctrl_ff[TEST_MODE_BIT]) begin
			pipe_valid_ff  <= lfifo_valid;
			pipe_data_ff   <= lfifo_data;
			pipe_ctrl_n_ff <= link_control_word_indication_n;
			pipe_err_n_ff  <= link_error_indication_n;
		end else begin
			pipe_valid_ff  <= 1'b0;
		end
	end

	// block tracking and fragment truncation
	assign drop     = cls_valid && !cls_start && blk_ff == ECC_BLK_OPEN
		&& frag_cnt_ff >= max_size_ff;
	assign ovfl_evt = drop && !trunc_ff;
	assign dbl_evt  = cls_valid && ((cls_start && blk_ff == ECC_BLK_OPEN)
		|| (cls_end && blk_ff != ECC_BLK_OPEN));
	assign err_evt  = cls_valid && !cls_err_n;

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			blk_ff      <= ECC_BLK_IDLE;
			frag_cnt_ff <= 18'h0;
			trunc_ff    <= 1'b0;
		end else if (cls_valid) begin
			case (blk_ff)
				ECC_BLK_IDLE: begin
					if (cls_start) begin
						blk_ff <= ECC_BLK_OPEN;
					end
				end
				ECC_BLK_OPEN: begin
					if (cls_end && !cls_start) begin
						blk_ff <= ECC_BLK_IDLE;
					end
				end
				default: blk_ff <= ECC_BLK_IDLE;
			endcase
			if (cls_start) begin
				frag_cnt_ff <= 18'h0;
				trunc_ff    <= 1'b0;
			end else if (drop) begin
				trunc_ff    <= 1'b1;
			end else begin
				frag_cnt_ff <= frag_cnt_ff + 18'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			mem_wr_ff   <= 1'b0;
			mem_addr_ff <= 18'h0;
			mem_data_ff <= RST_WORD;
		end else begin
			mem_wr_ff   <= cls_valid && !drop;
			mem_addr_ff <= cls_addr;
			mem_data_ff <= cls_data;
		end
	end

	// irq0: level sources sample masks; a set beats a clear
	always_comb begin
		nxt_irq0 = irq0_stat_ff;
		if (wr_hit && reg_addr == OFS_IRQ_ZERO_CONTROL) begin
			nxt_irq0 = nxt_irq0 & ~reg_wdata[2:0];
		end
		if (sum_empty && irq0_mask_ff[IRQ0_EMPTY_BIT]) begin
			nxt_irq0[IRQ0_EMPTY_BIT] = 1'b1;
		end
		if (sum_full && irq0_mask_ff[IRQ0_FULL_BIT]) begin
			nxt_irq0[IRQ0_FULL_BIT] = 1'b1;
		end
		if (ovfl_evt && irq0_mask_ff[IRQ0_OVFL_BIT]) begin
			nxt_irq0[IRQ0_OVFL_BIT] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			irq0_stat_ff <= RST_IRQ0[2:0];
		end else begin
			irq0_stat_ff <= nxt_irq0;
		end
	end

	// captures: overrun only when host never read the pending address
	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			le_addr_ff   <= 18'h0;
			le_ovr_ff    <= 1'b0;
			le_act_ff    <= 1'b0;
			le_unread_ff <= 1'b0;
		end else if (err_evt) begin
			le_addr_ff   <= cls_addr;
			le_ovr_ff    <= le_ovr_ff || le_unread_ff;
			le_act_ff    <= 1'b1;
			le_unread_ff <= 1'b1;
		end else begin
			if (wr_hit && reg_addr == OFS_LINK_ERROR_CAPTURE) begin
				le_act_ff <= 1'b0;
				le_ovr_ff <= 1'b0;
			end
			if (rd_hit && reg_addr == OFS_LINK_ERROR_CAPTURE) begin
				le_unread_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			db_addr_ff   <= 18'h0;
			db_ovr_ff    <= 1'b0;
			db_act_ff    <= 1'b0;
			db_unread_ff <= 1'b0;
		end else if (dbl_evt) begin
			db_addr_ff   <= cls_addr;
			db_ovr_ff    <= db_ovr_ff || db_unread_ff;
			db_act_ff    <= 1'b1;
			db_unread_ff <= 1'b1;
		end else begin
			if (wr_hit && reg_addr == OFS_DOUBLE_BLOCK_CAPTURE) begin
				db_act_ff <= 1'b0;
				db_ovr_ff <= 1'b0;
			end
			if (rd_hit && reg_addr == OFS_DOUBLE_BLOCK_CAPTURE) begin
				db_unread_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			fifo_overflow_irq_out_n_ff <= 1'b1;
			link_error_irq_out_n_ff    <= 1'b1;
			double_block_irq_out_n_ff  <= 1'b1;
		end else begin
			fifo_overflow_irq_out_n_ff <= !(|irq0_stat_ff);
			link_error_irq_out_n_ff    <= !le_act_ff;
			double_block_irq_out_n_ff  <= !db_act_ff;
		end
	end

	// page assembly; slots of disabled flags keep stale data
	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			prev1_ff  <= RST_WORD;
			prev2_ff  <= RST_WORD;
			commit_ff <= 1'b0;
		end else begin
			commit_ff <= cls_valid && cls_end && !cls_start;
			if (cls_valid && !cls_end) begin
				prev1_ff <= cls_data;
				prev2_ff <= prev1_ff;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (cls_valid && cls_start) begin
			page_ff[POS_START_WORD] <= cls_data;
			page_ff[POS_START_ADDR] <= cls_addr == 18'h0 ? RST_WORD : {14'h0, cls_addr};
		end
		for (int i = 0; i < 3; i++) begin
			if (cls_valid && cls_start_flag[i]) begin
				page_ff[POS_START_FLAG+i] <= cls_data;
			end
		end
		if (cls_valid && cls_end && !cls_start) begin
			if (end_en_ff[0]) begin
				page_ff[POS_END_FLAG0] <= prev2_ff;
			end
			if (end_en_ff[1]) begin
				page_ff[POS_END_FLAG1] <= prev1_ff;
			end
			page_ff[POS_END_WORD] <= cls_data;
		end
	end

	// summary fifo: whole pages in, single words out; full drops the page
	assign sum_empty = {wr_page_ff, 3'h0} == rd_ptr_ff;
	assign sum_full  = wr_page_ff[1:0] == rd_ptr_ff[4:3] && wr_page_ff[2] != rd_ptr_ff[5];

	always_ff @(posedge ref_clk) begin
		if (commit_ff && !sum_full) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				sum_mem[{wr_page_ff[1:0], 3'(i)}] <= page_ff[i];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			wr_page_ff <= 3'h0;
		end else if (commit_ff && !sum_full) begin
			wr_page_ff <= wr_page_ff + 3'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			rd_ptr_ff    <= 6'h0;
			sum_rdata_ff <= RST_WORD;
		end else if (sum_sel && sum_rd && !sum_empty) begin
			sum_rdata_ff <= sum_mem[rd_ptr_ff[4:0]];
			rd_ptr_ff    <= rd_ptr_ff + 6'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (lrst) begin
			host_flag_fifo_empty_ff <= 1'b1;
		end else begin
			host_flag_fifo_empty_ff <= sum_empty;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (lrst);

	property p_end_en;
		wr_hit && reg_addr == OFS_END_FLAG_LAST |=> end_en_ff[1] == $past(reg_wdata[0]);
	endproperty
	a_end_en: assert property (p_end_en) else $error("end flag enable not stored");

	property p_trunc;
		drop |=> !mem_wr_ff;
	endproperty
	a_trunc: assert property (p_trunc) else $error("oversize word written");

	property p_irq0_clr;
		wr_hit && reg_addr == OFS_IRQ_ZERO_CONTROL && reg_wdata[2] && !ovfl_evt
			|=> !irq0_stat_ff[2];
	endproperty
	a_irq0_clr: assert property (p_irq0_clr) else $error("overflow status not cleared");

	property p_irq0_mask;
		!irq0_mask_ff[0] && !irq0_stat_ff[0] |=> !irq0_stat_ff[0];
	endproperty
	a_irq0_mask: assert property (p_irq0_mask) else $error("masked status set");

	property p_le_addr;
		err_evt |=> le_addr_ff == $past(cls_addr) && le_act_ff ##1 !link_error_irq_out_n_ff;
	endproperty
	a_le_addr: assert property (p_le_addr) else $error("link error not captured");

	property p_le_ovr;
		err_evt && le_unread_ff |=> le_ovr_ff;
	endproperty
	a_le_ovr: assert property (p_le_ovr) else $error("overrun not flagged");

	property p_db_clr;
		wr_hit && reg_addr == OFS_DOUBLE_BLOCK_CAPTURE && !dbl_evt
			|=> !db_act_ff ##1 double_block_irq_out_n_ff;
	endproperty
	a_db_clr: assert property (p_db_clr) else $error("double irq not released");

	property p_dbl;
		cls_valid && cls_start && blk_ff == ECC_BLK_OPEN |=> ##1 !double_block_irq_out_n_ff;
	endproperty
	a_dbl: assert property (p_dbl) else $error("double start missed");

	property p_test_mode;
		test_ctrl_ff[TEST_MODE_BIT] || !host_flag_freeze_n |=> !link_take_ff;
	endproperty
	a_test_mode: assert property (p_test_mode) else $error("link taken in test or freeze");

	property p_inject;
		inj |=> pipe_valid_ff && pipe_data_ff == $past(test_data_ff);
	endproperty
	a_inject: assert property (p_inject) else $error("test word not injected");

	property p_empty_flag;
		sum_empty |=> host_flag_fifo_empty_ff;
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty flag low");

	c_inject: cover property (inj);
	c_commit: cover property (commit_ff && !sum_full);
	c_double: cover property (dbl_evt);
	c_trunc:  cover property (ovfl_evt);
endmodule

// ==== sim/ecc_host_model.sv ====
`timescale 1ns/100ps
module ecc_host_model
	import ecc_pkg::*;
(
	input  wire logic        ref_clk,
	output logic             reg_sel,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [4:0]  reg_addr,
	output logic      [31:0] reg_wdata,
	input  wire logic [31:0] reg_rdata_ff,
	output logic             sum_sel,
	output logic             sum_rd,
	input  wire logic [31:0] sum_rdata_ff,
	output logic             host_flag_link_rst_n,
	output logic             host_flag_logic_rst_n,
	output logic             host_flag_freeze_n
);
	initial begin
		{reg_sel, reg_wr, reg_rd, sum_sel, sum_rd} = 5'h00;
		reg_addr = 5'h00;
		reg_wdata = 32'h0000_0000;
		{host_flag_link_rst_n, host_flag_logic_rst_n, host_flag_freeze_n} = 3'h7;
	end
	// released lines show the inverse so a stale value never reads as data
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		#1;
		{reg_sel, reg_wr} = 2'h3;
		reg_addr = a;
		reg_wdata = d;
		@(posedge ref_clk);
		#1;
		{reg_sel, reg_wr} = 2'h0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		@(posedge ref_clk);
		#1;
		{reg_sel, reg_rd} = 2'h3;
		reg_addr = a;
		@(posedge ref_clk);
		#1;
		{reg_sel, reg_rd} = 2'h0;
		reg_addr = ~a;
		@(posedge ref_clk);
		#1;
		q = reg_rdata_ff;
	endtask
	task automatic pop(output logic [31:0] q);
		@(posedge ref_clk);
		#1;
		{sum_sel, sum_rd} = 2'h3;
		@(posedge ref_clk);
		#1;
		{sum_sel, sum_rd} = 2'h0;
		@(posedge ref_clk);
		#1;
		q = sum_rdata_ff;
	endtask
	task automatic flags(input logic link_n, input logic logic_n, input logic freeze_n);
		@(posedge ref_clk);
		#1;
		host_flag_link_rst_n = link_n;
		host_flag_logic_rst_n = logic_n;
		host_flag_freeze_n = freeze_n;
	endtask
	task automatic test_word(input logic [31:0] d, input logic [31:0] st);
		wr(OFS_TEST_CONTROL, 32'h0000_0002);
		wr(OFS_TEST_LINK_DATA, d);
		wr(OFS_TEST_LINK_STATUS, st);
		wr(OFS_TEST_CONTROL, 32'h0000_0003);
		wr(OFS_TEST_CONTROL, 32'h0000_0002);
	endtask
	// freeze outlasts the link restart so no garbage reaches a cleared pipeline
	task automatic init();
		flags(1'b1, 1'b0, 1'b0);
		@(posedge ref_clk);
		flags(1'b1, 1'b1, 1'b0);
		flags(1'b0, 1'b1, 1'b0);
		repeat (4) @(posedge ref_clk);
		flags(1'b1, 1'b1, 1'b0);
		repeat (4) @(posedge ref_clk);
		flags(1'b1, 1'b1, 1'b1);
	endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
	import ecc_pkg::*;
;
	logic        ref_clk, rstn, reg_sel, reg_wr, reg_rd, sum_sel, sum_rd, cls_valid;
	logic        host_flag_link_rst_n, host_flag_logic_rst_n, host_flag_freeze_n;
	logic        host_flag_fifo_empty_ff, link_interface_reset_n_ff, logic_rst_n_ff;
	logic        lfifo_valid, link_control_word_indication_n, link_error_indication_n;
	logic        link_take_ff, pipe_valid_ff, pipe_ctrl_n_ff, pipe_err_n_ff;
	logic        cls_start, cls_end, cls_err_n, mem_wr_ff, last_ctrl_n, last_err_n;
	logic        fifo_overflow_irq_out_n_ff, link_error_irq_out_n_ff, double_block_irq_out_n_ff;
	logic [4:0]  reg_addr;
	logic [2:0]  cls_start_flag;
	logic [17:0] cls_addr, mem_addr_ff, last_mem;
	logic [31:0] reg_wdata, reg_rdata_ff, sum_rdata_ff, lfifo_data, pipe_data_ff;
	logic [31:0] cls_data, mem_data_ff, q, last_pipe, e, last_md;
	int          n_mismatch, n_compared, n_pipe, n_mem;

	ecc_event_capture_control_regs dut_u (.ref_clk, .rstn, .reg_sel, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata_ff, .sum_sel, .sum_rd, .sum_rdata_ff,
		.host_flag_link_rst_n, .host_flag_logic_rst_n, .host_flag_freeze_n,
		.host_flag_fifo_empty_ff, .link_interface_reset_n_ff, .logic_rst_n_ff, .lfifo_valid,
		.lfifo_data, .link_control_word_indication_n, .link_error_indication_n, .link_take_ff,
		.pipe_valid_ff, .pipe_data_ff, .pipe_ctrl_n_ff, .pipe_err_n_ff, .cls_valid, .cls_data,
		.cls_start, .cls_end, .cls_err_n, .cls_addr, .cls_start_flag, .mem_wr_ff, .mem_addr_ff,
		.mem_data_ff, .fifo_overflow_irq_out_n_ff, .link_error_irq_out_n_ff,
		.double_block_irq_out_n_ff);
	ecc_host_model host_u (.ref_clk, .reg_sel, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata_ff, .sum_sel, .sum_rd, .sum_rdata_ff, .host_flag_link_rst_n,
		.host_flag_logic_rst_n, .host_flag_freeze_n);

	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (pipe_valid_ff === 1'b1) begin
			n_pipe++;
			{last_pipe, last_ctrl_n, last_err_n} = {pipe_data_ff, pipe_ctrl_n_ff, pipe_err_n_ff};
		end
		if (mem_wr_ff === 1'b1) begin
			n_mem++;
			last_mem = mem_addr_ff;
			last_md = mem_data_ff;
		end
	end

	task automatic chk32(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic chk1(input string nm, input logic x, input logic g);
		chk32(nm, {31'h0, x}, {31'h0, g});
	endtask
	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] x);
		host_u.rd(a, q);
		chk32(nm, x, q);
	endtask
	task automatic cls(input logic [31:0] d, input logic [2:0] se, input logic [17:0] a,
			input logic [2:0] f);
		@(posedge ref_clk);
		#1;
		{cls_valid, cls_data, cls_start, cls_end, cls_err_n} = {1'b1, d, se};
		{cls_addr, cls_start_flag} = {a, f};
		@(posedge ref_clk);
		#1;
		{cls_valid, cls_start, cls_end, cls_err_n} = 4'h1;
		cls_data = ~d;
	endtask
	task automatic done(input string nm);
		repeat (4) @(posedge ref_clk);
		$display("test %s finished", nm);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge ref_clk);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		{ref_clk, rstn, lfifo_valid, cls_valid, cls_start, cls_end} = 6'h00;
		{link_control_word_indication_n, link_error_indication_n, cls_err_n} = 3'h7;
		{lfifo_data, cls_data, cls_addr, cls_start_flag} = 85'h0;
		{n_mismatch, n_compared, n_pipe, n_mem} = 128'h0;
		repeat (10) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		host_u.init();
		rd_chk("max size", OFS_MAX_FRAGMENT_SIZE, 32'h0003_ffff);
		rd_chk("irq0 reg", OFS_IRQ_ZERO_CONTROL, 32'h0);
		rd_chk("test ctl", OFS_TEST_CONTROL, 32'h0);
		rd_chk("unmapped", 5'h05, 32'h0);
		chk1("empty flag", 1'b1, host_flag_fifo_empty_ff);
		chk1("irq0 out", 1'b1, fifo_overflow_irq_out_n_ff);
		chk1("irq1 out", 1'b1, link_error_irq_out_n_ff);
		chk1("irq2 out", 1'b1, double_block_irq_out_n_ff);
		@(posedge ref_clk);
		#1;
		rstn = 1'b0;
		repeat (2) @(posedge ref_clk);
		chk1("logic rst", 1'b0, logic_rst_n_ff);
		chk1("link rst", 1'b1, link_interface_reset_n_ff);
		#1;
		rstn = 1'b1;
		done("reset");

		host_u.wr(OFS_END_FLAG_SECOND_LAST, 32'h1);
		host_u.wr(OFS_END_FLAG_LAST, 32'h1);
		host_u.wr(OFS_MAX_FRAGMENT_SIZE, 32'h0000_a5a5);
		host_u.wr(OFS_TEST_LINK_DATA, 32'ha5c3_3c5a);
		host_u.wr(OFS_TEST_LINK_STATUS, 32'h2);
		rd_chk("end flag 0", OFS_END_FLAG_SECOND_LAST, 32'h1);
		rd_chk("end flag 1", OFS_END_FLAG_LAST, 32'h1);
		rd_chk("max size", OFS_MAX_FRAGMENT_SIZE, 32'h0000_a5a5);
		rd_chk("test data", OFS_TEST_LINK_DATA, 32'ha5c3_3c5a);
		rd_chk("test stat", OFS_TEST_LINK_STATUS, 32'h2);
		host_u.wr(OFS_IRQ_ZERO_CONTROL, 32'h08);
		rd_chk("irq0 empty", OFS_IRQ_ZERO_CONTROL, 32'h09);
		chk1("irq0 out", 1'b0, fifo_overflow_irq_out_n_ff);
		// mask first: a live empty source re-sets the bit in the clearing cycle
		host_u.wr(OFS_IRQ_ZERO_CONTROL, 32'h00);
		rd_chk("irq0 held", OFS_IRQ_ZERO_CONTROL, 32'h01);
		host_u.wr(OFS_IRQ_ZERO_CONTROL, 32'h01);
		rd_chk("irq0 clear", OFS_IRQ_ZERO_CONTROL, 32'h0);
		chk1("irq0 out", 1'b1, fifo_overflow_irq_out_n_ff);
		done("registers");

		// link words wait on the input while test mode must shut them out
		host_u.wr(OFS_TEST_CONTROL, 32'h2);
		{lfifo_valid, lfifo_data} = {1'b1, 32'h1111_2222};
		repeat (3) @(posedge ref_clk);
		chk1("take in test", 1'b0, link_take_ff);
		n_pipe = 0;
		host_u.test_word(32'h5a0f_c3e1, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk32("injected", 32'h1, 32'(n_pipe));
		chk32("inj data", 32'h5a0f_c3e1, last_pipe);
		chk1("inj ctrl", 1'b1, last_ctrl_n);
		chk1("inj err", 1'b0, last_err_n);
		host_u.wr(OFS_TEST_CONTROL, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk1("take normal", 1'b1, link_take_ff);
		host_u.flags(1'b1, 1'b1, 1'b0);
		repeat (3) @(posedge ref_clk);
		n_pipe = 0;
		repeat (4) @(posedge ref_clk);
		chk1("take frozen", 1'b0, link_take_ff);
		chk32("frozen words", 32'h0, 32'(n_pipe));
		host_u.flags(1'b0, 1'b1, 1'b1);
		repeat (3) @(posedge ref_clk);
		chk1("link rst", 1'b0, link_interface_reset_n_ff);
		chk1("take link rst", 1'b0, link_take_ff);
		host_u.flags(1'b1, 1'b1, 1'b1);
		lfifo_valid = 1'b0;
		done("test mode");

		n_mem = 0;
		for (int i = 0; i < 7; i++)
			cls({16'hc0de, 16'(i)}, {i == 0, i == 6, 1'b1}, 18'h100 + 18'(i),
				(i >= 1 && i <= 3) ? 3'(1 << (i - 1)) : 3'h0);
		repeat (3) @(posedge ref_clk);
		chk32("block writes", 32'h7, 32'(n_mem));
		chk1("empty flag", 1'b0, host_flag_fifo_empty_ff);
		for (int k = 0; k < 8; k++) begin
			host_u.pop(q);
			e = (k == 0) ? 32'hc0de_0000 : (k == 1) ? 32'h100 : {16'hc0de, 16'(k - 1)};
			chk32("page word", e, q);
		end
		repeat (3) @(posedge ref_clk);
		chk1("empty flag", 1'b1, host_flag_fifo_empty_ff);
		done("page");

		cls(32'he0e0_0001, 3'b011, 18'h200, 3'h0);
		repeat (4) @(posedge ref_clk);
		chk1("irq2 out", 1'b0, double_block_irq_out_n_ff);
		rd_chk("double end", OFS_DOUBLE_BLOCK_CAPTURE, 32'h200);
		host_u.wr(OFS_DOUBLE_BLOCK_CAPTURE, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk1("irq2 clear", 1'b1, double_block_irq_out_n_ff);
		cls(32'hb0b0_0001, 3'b101, 18'h300, 3'h0);
		cls(32'hb0b0_0002, 3'b101, 18'h301, 3'h0);
		repeat (4) @(posedge ref_clk);
		rd_chk("double start", OFS_DOUBLE_BLOCK_CAPTURE, 32'h301);
		host_u.wr(OFS_DOUBLE_BLOCK_CAPTURE, 32'h0);
		cls(32'he0e0_0002, 3'b011, 18'h302, 3'h0);
		done("double block");

		host_u.wr(OFS_MAX_FRAGMENT_SIZE, 32'h2);
		host_u.wr(OFS_IRQ_ZERO_CONTROL, 32'h20);
		n_mem = 0;
		for (int i = 0; i < 4; i++)
			cls(32'h7700_0000 + 32'(i), {i == 0, 2'b01}, 18'h400 + 18'(i), 3'h0);
		repeat (4) @(posedge ref_clk);
		chk32("kept words", 32'h3, 32'(n_mem));
		chk32("last kept", 32'h402, {14'h0, last_mem});
		chk32("kept data", 32'h7700_0002, last_md);
		rd_chk("irq0 ovfl", OFS_IRQ_ZERO_CONTROL, 32'h24);
		chk1("irq0 out", 1'b0, fifo_overflow_irq_out_n_ff);
		host_u.wr(OFS_IRQ_ZERO_CONTROL, 32'h24);
		rd_chk("irq0 clear", OFS_IRQ_ZERO_CONTROL, 32'h20);
		cls(32'he0e0_0003, 3'b011, 18'h404, 3'h0);
		done("truncation");

		cls(32'h0bad_0001, 3'b000, 18'h500, 3'h0);
		repeat (4) @(posedge ref_clk);
		chk1("irq1 out", 1'b0, link_error_irq_out_n_ff);
		rd_chk("err addr", OFS_LINK_ERROR_CAPTURE, 32'h500);
		cls(32'h0bad_0002, 3'b000, 18'h501, 3'h0);
		cls(32'h0bad_0003, 3'b000, 18'h502, 3'h0);
		repeat (4) @(posedge ref_clk);
		rd_chk("err overrun", OFS_LINK_ERROR_CAPTURE, 32'h0004_0502);
		host_u.wr(OFS_LINK_ERROR_CAPTURE, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk1("irq1 clear", 1'b1, link_error_irq_out_n_ff);
		done("link error");

		host_u.wr(OFS_MAX_FRAGMENT_SIZE, 32'h5);
		host_u.flags(1'b1, 1'b0, 1'b1);
		repeat (2) @(posedge ref_clk);
		chk1("logic rst", 1'b0, logic_rst_n_ff);
		host_u.flags(1'b1, 1'b1, 1'b1);
		rd_chk("max size", OFS_MAX_FRAGMENT_SIZE, 32'h0003_ffff);
		chk1("empty flag", 1'b1, host_flag_fifo_empty_ff);
		done("logic reset");
		tally_and_finish();
	end
endmodule
